// >>> design/adapter_control.sv
// adapter control register: strap readback, reset/halt control, pseudo-dma handshake
`timescale 1ns/1ps

// Operation
// [R1] bits 0-2 read the live network strap pin levels
// [R2] strap codes: LLH full-duplex, LHH 16M ring, HLH half-duplex, HHH 4M ring
// [R3] bit 3 reserved; read value undefined (returns zero here)
// [R4] hold-ack bit cannot be written to one while pseudo-dma disabled
// [R5] with pseudo-dma on, hold-ack bit replaces the hold-ack pin
// [R6] pseudo-dma state: idle, request interrupt, or transfer in progress
// [R7] bit 5 reads pseudo-dma direction, 1 means device to host
// [R8] bit 6 reads bus request, inverted in motorola mode, 1 means requested
// [R9] bit 7 selects pseudo-dma, set only by write, resets to zero
// [R10] bit 8 holds the device in reset; register access stays alive
// [R11] any clock failure sets the adapter reset bit; a one-cycle CLOCK_FAIL pulse is dropped here
// [R12] bit 9 halts the processor from internal buses
// [R13] bit 10 picks rom or ram boot, steering strobe and rom enable
// [R14] protected bits write only while adapter reset is one
// [R15] halt and boot reset from boot strap, parity from parity strap
// [R16] reset values of hold-ack, request, enable, reset, priority, irq enable, selects
// [R17] bit 11 sets local bus priority for external master
// [R18] irq when pseudo-dma requests without ack, or enabled status flag
// [R19] bit 13 enables odd parity checking
// [R20] bits 14-15 drive network select pins, changed only in adapter reset
// [R21] select code: speed bit first, type bit second
// [R22] power-up select is 16 megabit token ring
// [R23] host reaches register at select 100; byte lanes in 8-bit mode
module adapter_control (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // direct io register port
  input  wire logic        REG_SEL_EN,
  input  wire logic [2:0]  REG_SEL,
  input  wire logic        REG_WR,
  input  wire logic [1:0]  REG_BYTE_EN,
  input  wire logic [15:0] REG_WDATA,
  output logic      [15:0] REG_RDATA,
  // straps and pins
  input  wire logic [2:0]  NET_STRAP,
  input  wire logic        BOOT_STRAP_PIN,
  input  wire logic        PARITY_STRAP_PIN,
  input  wire logic        INTEL_MODE,
  input  wire logic        HOST_HOLD_ACK_IN,
  input  wire logic        HOST_BUS_REQUEST_OUT,
  input  wire logic        DMA_DIRECTION_OUT,
  input  wire logic        HOST_STATUS_IRQ,
  input  wire logic        CLOCK_FAIL,
  // control outputs
  output logic             SYSTEM_IRQ_OUT,
  output logic             CORE_RESET,
  output logic             PROCESSOR_HALT,
  output logic             BOOT_RAM,
  output logic             ROM_ENABLE_GATE,
  output logic             CAS_ENABLE_GATE,
  output logic             LOCAL_BUS_PRIORITY,
  output logic             PARITY_CHECK_ENABLE,
  output logic             NET_SELECT_SPEED,
  output logic             NET_SELECT_TYPE,
  output logic             HOLD_ACK_EFFECTIVE,
  output logic [1:0]       PDMA_STATE
);

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1, s2, s3;
  logic [NSYNC-1:0] pin_q;
  logic [NSYNC-1:0] next_pin_q;

  assign pin_raw = {PARITY_STRAP_PIN, BOOT_STRAP_PIN, CLOCK_FAIL, HOST_STATUS_IRQ,
                    DMA_DIRECTION_OUT, HOST_BUS_REQUEST_OUT, HOST_HOLD_ACK_IN, INTEL_MODE,
                    NET_STRAP};

  // a change is taken only once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_comb begin
        next_pin_q[g] = (s2[g] == s3[g]) ? s3[g] : pin_q[g];
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      pin_q <= '0;
    end else begin
      s1    <= pin_raw;
      s2    <= s1;
      s3    <= s2;
      pin_q <= next_pin_q;
    end
  end

  logic [2:0] strap_q;
  logic       intel_q, hold_pin_q, bus_req_q, dir_q, status_irq_q, clk_fail_q;
  logic       boot_pin_q, parity_pin_q;
  assign strap_q      = pin_q[2:0];
  assign intel_q      = pin_q[3];
  assign hold_pin_q   = pin_q[4];
  assign bus_req_q    = pin_q[5];
  assign dir_q        = pin_q[6];
  assign status_irq_q = pin_q[7];
  assign clk_fail_q   = pin_q[8];
  assign boot_pin_q   = pin_q[9];
  assign parity_pin_q = pin_q[10];

  // ********************************************************
  // strap capture after reset release
  // ********************************************************
  // straps are re-read until the synchroniser has filled after release;
  // a protected write landing in those first cycles overrides the strap value
  localparam logic [2:0] STRAP_SETTLE = 3'(adapter_control_pkg::SYNC_DEPTH + 2);
  logic [2:0] strap_count;
  logic [2:0] next_strap_count;
  logic       strap_taken;

  assign strap_taken = (strap_count == STRAP_SETTLE);

  function automatic logic byte_hit(input logic [1:0] be, input int lane);
    return be[lane];
  endfunction

  // ********************************************************
  // control register
  // ********************************************************
  adapter_control_pkg::ctrl_s ctrl, next_ctrl;
  logic wr_hit;
  logic bus_req_level;

  assign wr_hit        = REG_SEL_EN && REG_WR && (REG_SEL == adapter_control_pkg::SEL_ADAPTER_CONTROL); // [R23]
  assign bus_req_level = intel_q ? bus_req_q : ~bus_req_q; // [R8]

  always_comb begin
    next_ctrl        = ctrl;
    next_strap_count = strap_taken ? strap_count : strap_count + 3'h1;
    if (!strap_taken) begin
      next_ctrl.halt   = boot_pin_q; // [R15]
      next_ctrl.boot   = boot_pin_q; // [R15]
      next_ctrl.parity = parity_pin_q; // [R15]
    end
    if (wr_hit && byte_hit(REG_BYTE_EN, 0)) begin
      // protected low-byte bit judged on the current reset bit
      if (ctrl.adapter_reset && (REG_WDATA[adapter_control_pkg::PDMA_EN_BIT] || ctrl.pdma_en))
        next_ctrl.hold_ack = REG_WDATA[adapter_control_pkg::HOLD_ACK_BIT]; // [R4] [R14]
      else if (ctrl.adapter_reset)
        next_ctrl.hold_ack = 1'b0; // [R4]
      if (REG_WDATA[adapter_control_pkg::PDMA_EN_BIT])
        next_ctrl.pdma_en = 1'b1; // [R9]
    end
    if (wr_hit && byte_hit(REG_BYTE_EN, 1)) begin
      next_ctrl.adapter_reset = REG_WDATA[adapter_control_pkg::ADAPTER_RESET_BIT]; // [R10]
      next_ctrl.local_bus_priority    = REG_WDATA[adapter_control_pkg::LBP_BIT]; // [R17]
      next_ctrl.irq_en = REG_WDATA[adapter_control_pkg::IRQ_EN_BIT]; // [R18]
      if (ctrl.adapter_reset) begin
        next_ctrl.halt     = REG_WDATA[adapter_control_pkg::HALT_BIT]; // [R12] [R14]
        next_ctrl.boot     = REG_WDATA[adapter_control_pkg::BOOT_BIT]; // [R13] [R14]
        next_ctrl.parity   = REG_WDATA[adapter_control_pkg::PARITY_BIT]; // [R19] [R14]
        next_ctrl.speed    = REG_WDATA[adapter_control_pkg::SPEED_BIT]; // [R20] [R21]
        next_ctrl.net_type = REG_WDATA[adapter_control_pkg::TYPE_BIT]; // [R20] [R21]
      end
    end
    if (clk_fail_q)
      next_ctrl.adapter_reset = 1'b1; // [R11]
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      strap_count      <= 3'h0;
      ctrl.hold_ack    <= adapter_control_pkg::RST_HOLD_ACK; // [R16]
      ctrl.pdma_en     <= adapter_control_pkg::RST_PDMA_EN;
      ctrl.adapter_reset      <= adapter_control_pkg::RST_ADAPTER_RESET;
      ctrl.halt        <= 1'b0;
      ctrl.boot        <= 1'b0;
      ctrl.local_bus_priority         <= adapter_control_pkg::RST_LBP;
      ctrl.irq_en      <= adapter_control_pkg::RST_IRQ_EN;
      ctrl.parity      <= 1'b0;
      ctrl.speed       <= adapter_control_pkg::RST_SPEED; // [R22]
      ctrl.net_type    <= adapter_control_pkg::RST_TYPE; // [R22]
    end else begin
      strap_count <= next_strap_count;
      ctrl        <= next_ctrl;
    end
  end

  // ********************************************************
  // pseudo-dma decode, readback and outputs
  // ********************************************************
  logic                             hold_eff;
  adapter_control_pkg::pdma_state_e pdma_state;
  logic [15:0]                      next_rdata;
  logic                             next_irq;

  assign hold_eff = ctrl.pdma_en ? ctrl.hold_ack : hold_pin_q; // [R5]

  always_comb begin
    case ({ctrl.pdma_en, ctrl.hold_ack, bus_req_level}) // [R6]
      3'b100:  pdma_state = adapter_control_pkg::PDMA_IDLE;
      3'b101:  pdma_state = adapter_control_pkg::PDMA_REQUEST;
      3'b110:  pdma_state = adapter_control_pkg::PDMA_ACTIVE;
      3'b111:  pdma_state = adapter_control_pkg::PDMA_ACTIVE;
      default: pdma_state = adapter_control_pkg::PDMA_OFF;
    endcase
  end

  always_comb begin
    next_rdata = 16'h0000;
    next_rdata[adapter_control_pkg::STRAP_HI:adapter_control_pkg::STRAP_LO] = strap_q; // [R1] [R2]
    next_rdata[adapter_control_pkg::RSVD_BIT]     = 1'b0; // [R3]
    next_rdata[adapter_control_pkg::HOLD_ACK_BIT] = ctrl.hold_ack;
    next_rdata[adapter_control_pkg::DIR_BIT]      = dir_q; // [R7]
    next_rdata[adapter_control_pkg::BUS_REQ_BIT]  = bus_req_level; // [R8]
    next_rdata[adapter_control_pkg::PDMA_EN_BIT]  = ctrl.pdma_en;
    next_rdata[adapter_control_pkg::ADAPTER_RESET_BIT]   = ctrl.adapter_reset;
    next_rdata[adapter_control_pkg::HALT_BIT]     = ctrl.halt;
    next_rdata[adapter_control_pkg::BOOT_BIT]     = ctrl.boot;
    next_rdata[adapter_control_pkg::LBP_BIT]      = ctrl.local_bus_priority;
    next_rdata[adapter_control_pkg::IRQ_EN_BIT]   = ctrl.irq_en;
    next_rdata[adapter_control_pkg::PARITY_BIT]   = ctrl.parity;
    next_rdata[adapter_control_pkg::SPEED_BIT]    = ctrl.speed;
    next_rdata[adapter_control_pkg::TYPE_BIT]     = ctrl.net_type;
    next_irq = (ctrl.pdma_en && bus_req_level && !ctrl.hold_ack)
             || (ctrl.irq_en && status_irq_q); // [R18]
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA           <= 16'h0000;
      SYSTEM_IRQ_OUT      <= 1'b0;
      CORE_RESET          <= 1'b1;
      PROCESSOR_HALT      <= 1'b0;
      BOOT_RAM            <= 1'b0;
      ROM_ENABLE_GATE     <= 1'b1;
      CAS_ENABLE_GATE     <= 1'b0;
      LOCAL_BUS_PRIORITY  <= 1'b0;
      PARITY_CHECK_ENABLE <= 1'b0;
      NET_SELECT_SPEED    <= adapter_control_pkg::RST_SPEED;
      NET_SELECT_TYPE     <= adapter_control_pkg::RST_TYPE;
      HOLD_ACK_EFFECTIVE  <= 1'b0;
      PDMA_STATE          <= adapter_control_pkg::PDMA_OFF;
    end else begin
      REG_RDATA           <= next_rdata;
      SYSTEM_IRQ_OUT      <= next_irq; // [R18]
      CORE_RESET          <= ctrl.adapter_reset; // [R10]
      PROCESSOR_HALT      <= ctrl.halt; // [R12]
      BOOT_RAM            <= ctrl.boot; // [R13]
      ROM_ENABLE_GATE     <= ~ctrl.boot; // [R13]
      CAS_ENABLE_GATE     <= ctrl.boot; // [R13]
      LOCAL_BUS_PRIORITY  <= ctrl.local_bus_priority; // [R17]
      PARITY_CHECK_ENABLE <= ctrl.parity; // [R19]
      NET_SELECT_SPEED    <= ctrl.speed; // [R20]
      NET_SELECT_TYPE     <= ctrl.net_type; // [R20]
      HOLD_ACK_EFFECTIVE  <= hold_eff; // [R5]
      PDMA_STATE          <= pdma_state; // [R6]
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  chk_hold_ack_guard: assert property (@(posedge SYS_CLK) disable iff (RST) // [R4]
    !ctrl.pdma_en && !$past(ctrl.pdma_en) |-> !ctrl.hold_ack)
    else $error("hold ack set without pseudo dma");
  chk_pdma_sticky: assert property (@(posedge SYS_CLK) disable iff (RST) // [R9]
    ctrl.pdma_en |=> ctrl.pdma_en)
    else $error("pseudo dma enable cleared");
  chk_protect_select: assert property (@(posedge SYS_CLK) disable iff (RST) // [R14]
    !ctrl.adapter_reset && strap_taken |=> $stable(ctrl.speed) && $stable(ctrl.net_type)
      && $stable(ctrl.parity))
    else $error("protected bit changed outside adapter reset");
  // adapter reset bit first, then the core reset output one edge later
  sequence seq_reset_follow;
    ctrl.adapter_reset ##1 CORE_RESET;
  endsequence

  chk_clock_fail: assert property (@(posedge SYS_CLK) disable iff (RST) // [R11]
    clk_fail_q |=> seq_reset_follow)
    else $error("clock failure did not set adapter reset");
  chk_irq_equation: assert property (@(posedge SYS_CLK) disable iff (RST) // [R18]
    ##1 SYSTEM_IRQ_OUT == $past((ctrl.pdma_en && bus_req_level && !ctrl.hold_ack)
      || (ctrl.irq_en && status_irq_q)))
    else $error("system irq mismatch");
  chk_hold_source: assert property (@(posedge SYS_CLK) disable iff (RST) // [R5]
    ctrl.pdma_en |=> HOLD_ACK_EFFECTIVE == $past(ctrl.hold_ack))
    else $error("hold ack pin not ignored");
  chk_select_pins: assert property (@(posedge SYS_CLK) disable iff (RST) // [R20]
    1'b1 |=> NET_SELECT_SPEED == $past(ctrl.speed) && NET_SELECT_TYPE == $past(ctrl.net_type))
    else $error("select pins not following register");
  chk_strap_read: assert property (@(posedge SYS_CLK) disable iff (RST) // [R1]
    1'b1 |=> REG_RDATA[2:0] == $past(strap_q))
    else $error("strap readback wrong");
  chk_boot_steer: assert property (@(posedge SYS_CLK) disable iff (RST) // [R13]
    1'b1 |=> ROM_ENABLE_GATE == !$past(ctrl.boot) && CAS_ENABLE_GATE == $past(ctrl.boot))
    else $error("boot steering inconsistent");
  chk_protect_core: assert property (@(posedge SYS_CLK) disable iff (RST) // [R14]
    !ctrl.adapter_reset && strap_taken |=> $stable(ctrl.halt) && $stable(ctrl.boot)
      && $stable(ctrl.hold_ack))
    else $error("protected control bit changed outside adapter reset");

endmodule

// >>> design/adapter_control_pkg.sv
// adapter control register constants, field positions and carrier types
package adapter_control_pkg;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int STRAP_LO     = 0;
  localparam int STRAP_HI     = 2;
  localparam int RSVD_BIT     = 3;
  localparam int HOLD_ACK_BIT = 4;
  localparam int DIR_BIT      = 5;
  localparam int BUS_REQ_BIT  = 6;
  localparam int PDMA_EN_BIT  = 7;
  localparam int ADAPTER_RESET_BIT   = 8;
  localparam int HALT_BIT     = 9;
  localparam int BOOT_BIT     = 10;
  localparam int LBP_BIT      = 11;
  localparam int IRQ_EN_BIT   = 12;
  localparam int PARITY_BIT   = 13;
  localparam int SPEED_BIT    = 14;
  localparam int TYPE_BIT     = 15;

  // ********************************************************
  // register select code and reset values
  // ********************************************************
  localparam logic [2:0] SEL_ADAPTER_CONTROL = 3'h4;
  localparam logic       RST_HOLD_ACK        = 1'h0;
  localparam logic       RST_PDMA_EN         = 1'h0;
  localparam logic       RST_ADAPTER_RESET          = 1'h0;
  localparam logic       RST_LBP             = 1'h0;
  localparam logic       RST_IRQ_EN          = 1'h1;
  localparam logic       RST_SPEED           = 1'h0;
  localparam logic       RST_TYPE            = 1'h1;

  // ********************************************************
  // network configuration codes, {speed, type}
  // ********************************************************
  localparam logic [1:0] NET_ETH_FULL = 2'h0;
  localparam logic [1:0] NET_TR_16    = 2'h1;
  localparam logic [1:0] NET_ETH_HALF = 2'h2;
  localparam logic [1:0] NET_TR_4     = 2'h3;

  // pin synchroniser depth
  localparam int SYNC_DEPTH = 3;

  typedef enum logic [1:0] {
    PDMA_IDLE    = 2'b00,
    PDMA_REQUEST = 2'b01,
    PDMA_ACTIVE  = 2'b10,
    PDMA_OFF     = 2'b11
  } pdma_state_e;

  typedef struct packed {
    logic hold_ack;
    logic pdma_en;
    logic adapter_reset;
    logic halt;
    logic boot;
    logic local_bus_priority;
    logic irq_en;
    logic parity;
    logic speed;
    logic net_type;
  } ctrl_s;

endpackage

// >>> verification/host_model.sv
// host processor model on the direct io register port
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic        clk,
  // register port
  output logic             sel_en,
  output logic [2:0]       sel,
  output logic             wr,
  output logic [1:0]       be,
  output logic [15:0]      wdata,
  // marks the cycle in which read data is settled
  output logic             rd_valid
);
  initial begin
    sel_en = 1'h0;
    sel = 3'h0;
    wr = 1'h0;
    be = 2'h0;
    wdata = 16'h0000;
    rd_valid = 1'h0;
  end

  // one-cycle write; lanes picked by byte enables
  task automatic write_reg(input logic [2:0] s, input logic [1:0] b, input logic [15:0] d);
    @(posedge clk);
    #1;
    sel_en = 1'h1;
    wr = 1'h1;
    sel = s;
    be = b;
    wdata = d;
    @(posedge clk);
    #1;
    sel_en = 1'h0;
    wr = 1'h0;
    wdata = ~d;
  endtask

  // readback is registered, so hold select two edges before sampling
  task automatic read_reg();
    @(posedge clk);
    #1;
    sel_en = 1'h1;
    wr = 1'h0;
    sel = adapter_control_pkg::SEL_ADAPTER_CONTROL;
    be = 2'h3;
    repeat (2) @(posedge clk);
    #1;
    sel_en = 1'h0;
    rd_valid = 1'h1;
    @(posedge clk);
    #1;
    rd_valid = 1'h0;
  endtask
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the adapter control register
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'h0, rst = 1'h1, sel_en, wr, rd_valid;
  logic [2:0] sel, strap = 3'h4;
  logic [1:0] be, pst;
  logic [15:0] wdata, rdata;
  logic boot_pin = 1'h0, par_pin = 1'h0, intel = 1'h1, hold_pin = 1'h0, bus_req = 1'h0;
  logic dir = 1'h0, stat_irq = 1'h0, cf = 1'h0;
  logic irq, core_rst, halt, boot_ram, rom_en, cas_en, local_bus_priority, par_en, spd, typ, hold_eff;
  logic m_hold, m_pdma, m_adapter_reset, m_halt, m_boot, m_lbp, m_irqen, m_par, m_speed, m_type;
  logic [31:0] exp_q[$];
  logic [31:0] got, want, w = 32'h00000000;
  integer seed = 32'hECE62DBC;
  int mismatches = 0, compares = 0;

  always #4 sys_clk = ~sys_clk;

  host_model host (.clk(sys_clk), .sel_en(sel_en), .sel(sel), .wr(wr), .be(be),
    .wdata(wdata), .rd_valid(rd_valid));

  adapter_control uut (.SYS_CLK(sys_clk), .RST(rst), .REG_SEL_EN(sel_en), .REG_SEL(sel),
    .REG_WR(wr), .REG_BYTE_EN(be), .REG_WDATA(wdata), .REG_RDATA(rdata), .NET_STRAP(strap),
    .BOOT_STRAP_PIN(boot_pin), .PARITY_STRAP_PIN(par_pin), .INTEL_MODE(intel),
    .HOST_HOLD_ACK_IN(hold_pin), .HOST_BUS_REQUEST_OUT(bus_req), .DMA_DIRECTION_OUT(dir),
    .HOST_STATUS_IRQ(stat_irq), .CLOCK_FAIL(cf), .SYSTEM_IRQ_OUT(irq), .CORE_RESET(core_rst),
    .PROCESSOR_HALT(halt), .BOOT_RAM(boot_ram), .ROM_ENABLE_GATE(rom_en),
    .CAS_ENABLE_GATE(cas_en), .LOCAL_BUS_PRIORITY(local_bus_priority), .PARITY_CHECK_ENABLE(par_en),
    .NET_SELECT_SPEED(spd), .NET_SELECT_TYPE(typ), .HOLD_ACK_EFFECTIVE(hold_eff),
    .PDMA_STATE(pst));

  // ********************************************************
  // reference model
  // ********************************************************
  function automatic logic [31:0] expect_vec();
    logic breq;
    logic [1:0] st;
    breq = intel ? bus_req : ~bus_req;
    st = m_pdma ? (m_hold ? 2'h2 : {1'h0, breq}) : 2'h3;
    return {3'h0, (m_pdma & breq & ~m_hold) | (m_irqen & stat_irq), m_adapter_reset, m_halt,
      m_boot, ~m_boot, m_boot, m_lbp, m_par, m_speed, m_type,
      m_pdma ? m_hold : hold_pin, st,
      m_type, m_speed, m_par, m_irqen, m_lbp, m_boot, m_halt, m_adapter_reset, m_pdma, breq, dir,
      m_hold, 1'h0, strap};
  endfunction

  task automatic do_reset(input logic bs, input logic ps);
    boot_pin = bs;
    par_pin = ps;
    cf = 1'h0;
    rst = 1'h1;
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'h0;
    {m_hold, m_pdma, m_adapter_reset, m_lbp, m_irqen, m_speed, m_type} = 7'h05;
    {m_halt, m_boot, m_par} = {bs, bs, ps};
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic host_write(input logic [2:0] s, input logic [1:0] b, input logic [15:0] d);
    logic prot;
    logic pd;
    prot = m_adapter_reset;
    pd = m_pdma | (b[0] & d[7]);
    if (s == adapter_control_pkg::SEL_ADAPTER_CONTROL) begin
      if (b[0] && prot) m_hold = d[4] & pd;
      m_pdma = pd;
      if (b[1]) begin
        m_adapter_reset = d[8] | cf;
        m_lbp = d[11];
        m_irqen = d[12];
        if (prot) {m_type, m_speed, m_par, m_boot, m_halt} = {d[15:13], d[10:9]};
      end
    end
    host.write_reg(s, b, d);
  endtask

  task automatic host_read();
    exp_q.push_back(expect_vec());
    host.read_reg();
  endtask

  // pins settle through the synchroniser before anything is checked
  task automatic shake_pins(input logic fail);
    @(posedge sys_clk);
    #1;
    w = $random(seed);
    {stat_irq, dir, bus_req, hold_pin, intel, strap} = w[7:0];
    cf = fail;
    repeat (8) @(posedge sys_clk);
    m_adapter_reset = m_adapter_reset | fail;
  endtask

  // ********************************************************
  // result checker
  // ********************************************************
  always @(negedge sys_clk) begin
    if (rd_valid === 1'h1) begin
      got = {3'h0, irq, core_rst, halt, boot_ram, rom_en, cas_en, local_bus_priority, par_en, spd, typ,
        hold_eff, pst, rdata};
      want = 32'hFFFFFFFF;
      if (exp_q.size() != 0) want = exp_q.pop_front();
      compares++;
      if ((got & 32'hFFFFFFF7) !== (want & 32'hFFFFFFF7)) begin
        mismatches++;
        $display("BAD t=%0t got=%h want=%h", $time, got, want);
      end
    end
  end

  task automatic tally_and_finish();
    if (exp_q.size() != 0) mismatches++;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    for (int i = 0; i < 2; i++) begin
      do_reset(~i[0], i[0]);
      host_read();
      $display("test reset_values done");
      host_write(3'h4, 2'h3, 16'h0110);
      host_read();
      host_write(3'h4, 2'h3, 16'h4990);
      host_read();
      host_write(3'h4, 2'h3, 16'h8000);
      host_write(3'h4, 2'h2, 16'hF200);
      host_read();
      $display("test protected_writes done");
      for (int n = 0; n < 150; n++) begin
        shake_pins(w[11:8] == 4'h0);
        w = $random(seed);
        host_write(w[18] ? 3'h4 : w[21:19], w[17:16], w[15:0]);
        host_read();
      end
      $display("test random_traffic done");
    end
    tally_and_finish();
  end
endmodule
